// ---- design/sdr_pkg.sv ----
package sdr_pkg;

    typedef logic [9:0] sdr_word_t;

    typedef struct packed {
        logic       rw;
        logic [4:0] addr;
        sdr_word_t  data;
    } sdr_frame_t;

    typedef struct packed {
        logic pos_gnd;
        logic neg_gnd;
        logic pos_sup;
        logic neg_sup;
    } sdr_short_t;

    typedef struct packed {
        logic       ready;
        logic       coil;
        logic       pol_bad;
        logic [4:0] value;
    } sdr_emf_t;

endpackage : sdr_pkg

// ---- design/sdr_regs.svh ----
`ifndef SDR_REGS_SVH
`define SDR_REGS_SVH

`define SDR_FAULT_SUM_ADDR 5'h05
`define SDR_PHASE_X_ADDR   5'h06
`define SDR_PHASE_Y_ADDR   5'h07
`define SDR_IDENT_ADDR     5'h08
`define SDR_EMF_ADDR       5'h09
`define SDR_SPEED_ADDR     5'h0A

`define SDR_ZERO_BIT       9
`define SDR_PARITY_BIT     8
`define SDR_STEP_LOSS_BIT  7
`define SDR_HARD_RST_BIT   6
`define SDR_DEFECT_BIT     5
`define SDR_COLD_BIT       4
`define SDR_LOW_WARN_BIT   3
`define SDR_THERM_WARN_BIT 2
`define SDR_LOW_SUPPLY_BIT 1
`define SDR_STALL_BIT      0
`define SDR_SPI_BIT        6
`define SDR_THERM_SHDN_BIT 5
`define SDR_OPEN_BIT   4
`define SDR_STEP_BIT   6
`define SDR_DIR_BIT    5
`define SDR_RDY_BIT    7
`define SDR_COIL_BIT   6
`define SDR_POL_BIT    5

`define SDR_FAULT_SUM_RST 10'h040
`define SDR_FRAME_BITS 16

`endif

// ---- design/sdr_status_regs.sv ----
`timescale 1ns/100ps
`include "sdr_regs.svh"
module sdr_status_regs #(
    parameter logic [4:0] DEV_ID = 5'h0A,
    parameter logic [2:0] REV_ID = 3'h1
) (
    input  wire logic               mclk_i,
    input  wire logic               rst_i,
    input  wire logic               sclk_i,
    input  wire logic               chip_select_low_n_i,
    input  wire logic               mosi_i,
    output logic                    miso_o,
    output logic                    miso_oe_o,
    input  wire logic               step_clock_input_i,
    input  wire logic               direction_input_i,
    input  wire logic               stall_det_i,
    input  wire logic               step_loss_det_i,
    input  wire logic               undervoltage_det_i,
    input  wire logic               undervoltage_warn_det_i,
    input  wire logic               thermal_shutdown_det_i,
    input  wire logic               thermal_warning_i,
    input  wire logic               cold_boost_allowed_i,
    input  wire logic               open_x_det_i,
    input  wire logic               open_y_det_i,
    input  wire sdr_pkg::sdr_short_t short_x_det_i,
    input  wire sdr_pkg::sdr_short_t short_y_det_i,
    input  wire sdr_pkg::sdr_emf_t  emf_i,
    input  wire logic [7:0]         speed_i,
    input  wire logic               undervoltage_action_bit_i,
    output logic                    bridge_open_o,
    output logic                    bridge_brake_o
);
    import sdr_pkg::*;

    // The identifier values above are arbitrary.

    ////////////////////////////////////////////////////////////////////////////
    // Link side, clocked by the serial clock.

    logic       link_rst;
    logic [3:0] bit_cnt_r;
    logic [3:0] bit_cnt_nxt;
    logic [14:0] rx_r;
    logic [15:0] tx_r;
    sdr_frame_t cmd_r;
    logic       req_tg_r;
    logic       misalign_r;
    sdr_frame_t resp_r;

    // The bit counter restarts with every frame; the command, toggle and
    // alignment level survive chip select so the core can still read them.
    assign link_rst    = rst_i | chip_select_low_n_i;
    assign bit_cnt_nxt = bit_cnt_r + 4'h1;

    always_ff @(posedge sclk_i or posedge link_rst)
    begin
        if (link_rst)
            bit_cnt_r <= 4'h0;
        else
            bit_cnt_r <= bit_cnt_nxt;
    end

    always_ff @(posedge sclk_i or posedge rst_i)
    begin
        if (rst_i)
            rx_r <= 15'h0000;
        else
            rx_r <= {rx_r[13:0], mosi_i};
    end

    always_ff @(posedge sclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cmd_r    <= '0;
            req_tg_r <= 1'b0;
        end
        else if (bit_cnt_r == 4'hF)
        begin
            cmd_r    <= sdr_frame_t'({rx_r, mosi_i});
            req_tg_r <= ~req_tg_r;
        end
    end

    // High whenever the edges seen so far do not fill whole words.
    always_ff @(posedge sclk_i or posedge rst_i)
    begin
        if (rst_i)
            misalign_r <= 1'b0;
        else
            misalign_r <= (bit_cnt_nxt != 4'h0);
    end

    // The answer word only changes after a request, long before the next
    // frame starts, so it is quasi-static when the link side loads it.
    always_ff @(posedge sclk_i or posedge rst_i)
    begin
        if (rst_i)
            tx_r <= 16'h0000;
        else if (bit_cnt_r == 4'h0)
            tx_r <= {resp_r[14:0], 1'b0};
        else
            tx_r <= {tx_r[14:0], 1'b0};
    end

    assign miso_o    = (bit_cnt_r == 4'h0) ? resp_r[15] : tx_r[15];
    assign miso_oe_o = ~chip_select_low_n_i;

    ////////////////////////////////////////////////////////////////////////////
    // Crossing into the core clock.

    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic       req_seen_r;
    logic       cs_seen_r;
    logic       req_fire;
    logic       frame_end;
    logic       cs_n_s;
    logic       misalign_s;
    logic       step_s;
    logic       dir_s;

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sync1_r <= 5'h01;
            sync2_r <= 5'h01;
        end
        else
        begin
            sync1_r <= {direction_input_i, step_clock_input_i, misalign_r,
                        req_tg_r, chip_select_low_n_i};
            sync2_r <= sync1_r;
        end
    end

    assign cs_n_s     = sync2_r[0];
    assign misalign_s = sync2_r[2];
    assign step_s     = sync2_r[3];
    assign dir_s      = sync2_r[4];

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            req_seen_r <= 1'b0;
            cs_seen_r  <= 1'b1;
        end
        else
        begin
            req_seen_r <= sync2_r[1];
            cs_seen_r  <= cs_n_s;
        end
    end

    assign req_fire  = sync2_r[1] ^ req_seen_r;
    assign frame_end = cs_n_s & ~cs_seen_r;

    ////////////////////////////////////////////////////////////////////////////
    // Latched flags: slot 0 first, 1 second, 2 third, 3 fifth register.

    localparam logic [4:0] LAT_ADDR [0:3] = '{`SDR_FAULT_SUM_ADDR, `SDR_PHASE_X_ADDR,
                                              `SDR_PHASE_Y_ADDR, `SDR_EMF_ADDR};

    sdr_word_t lat_r [0:3];
    sdr_word_t set_v [0:3];
    logic      rd_req;
    logic      clr_v [0:3];

    assign rd_req = req_fire & ~cmd_r.rw;

    always_comb
    begin
        set_v[0] = '0;
        set_v[1] = '0;
        set_v[2] = '0;
        set_v[3] = '0;
        // Detectors are levels, so a condition that is still present keeps
        // setting its latch, including right after reset and after a read.
        set_v[0][`SDR_STEP_LOSS_BIT]  = step_loss_det_i;
        set_v[0][`SDR_LOW_WARN_BIT]   = undervoltage_warn_det_i;
        set_v[0][`SDR_LOW_SUPPLY_BIT] = undervoltage_det_i;
        set_v[0][`SDR_STALL_BIT]      = stall_det_i;
        set_v[1][`SDR_SPI_BIT]        = frame_end & misalign_s;
        set_v[1][`SDR_THERM_SHDN_BIT] = thermal_shutdown_det_i;
        set_v[1][`SDR_OPEN_BIT]  = open_x_det_i;
        set_v[1][3:0]            = short_x_det_i;
        set_v[2][`SDR_OPEN_BIT]  = open_y_det_i;
        set_v[2][3:0]            = short_y_det_i;
        set_v[3][`SDR_RDY_BIT]   = emf_i.ready;
    end

    for (genvar g = 0; g < 4; g++)
    begin : g_lat
        assign clr_v[g] = rd_req && (cmd_r.addr == LAT_ADDR[g]);
        // Set wins over the read clear so no event is lost.
        always_ff @(posedge mclk_i or posedge rst_i)
        begin
            if (rst_i)
                lat_r[g] <= (g == 0) ? `SDR_FAULT_SUM_RST : 10'h000;
            else if (clr_v[g])
                lat_r[g] <= set_v[g];
            else
                lat_r[g] <= lat_r[g] | set_v[g];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read value assembly.

    logic      defect_live;
    sdr_word_t rd_word;

    assign defect_live = (|lat_r[1][4:0]) | (|lat_r[2][4:0]);

    always_comb
    begin
        rd_word = '0;
        case (cmd_r.addr)
            `SDR_FAULT_SUM_ADDR:
            begin
                rd_word                      = lat_r[0];
                rd_word[`SDR_DEFECT_BIT]     = defect_live;
                rd_word[`SDR_COLD_BIT]       = cold_boost_allowed_i;
                rd_word[`SDR_THERM_WARN_BIT] = thermal_warning_i;
            end
            `SDR_PHASE_X_ADDR:
                rd_word = lat_r[1];
            `SDR_PHASE_Y_ADDR:
            begin
                rd_word                = lat_r[2];
                rd_word[`SDR_STEP_BIT] = step_s;
                rd_word[`SDR_DIR_BIT]  = dir_s;
            end
            `SDR_IDENT_ADDR:
                rd_word[7:0] = {DEV_ID, REV_ID};
            `SDR_EMF_ADDR:
            begin
                rd_word                = lat_r[3];
                rd_word[`SDR_COIL_BIT] = emf_i.coil;
                rd_word[`SDR_POL_BIT]  = emf_i.pol_bad;
                rd_word[4:0]           = emf_i.value;
            end
            `SDR_SPEED_ADDR:
                rd_word[7:0] = speed_i;
            default:
                rd_word = '0;
        endcase
        if (cmd_r.addr >= `SDR_FAULT_SUM_ADDR && cmd_r.addr <= `SDR_SPEED_ADDR)
        begin
            rd_word[`SDR_ZERO_BIT]   = 1'b0;
            rd_word[`SDR_PARITY_BIT] = ~(^rd_word[7:0]);
        end
    end

    // Writes leave the answer and every latch untouched; the status bank
    // has nothing software can store.
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            resp_r <= '0;
        else if (rd_req)
            resp_r <= '{rw: 1'b0, addr: cmd_r.addr, data: rd_word};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Under-voltage bridge action.

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bridge_open_o  <= 1'b0;
            bridge_brake_o <= 1'b0;
        end
        else
        begin
            bridge_open_o  <= undervoltage_det_i & ~undervoltage_action_bit_i;
            bridge_brake_o <= undervoltage_det_i & undervoltage_action_bit_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    a_parity_odd: assert property (@(posedge mclk_i) disable iff (rst_i)
        (rd_req && cmd_r.addr >= `SDR_FAULT_SUM_ADDR && cmd_r.addr <= `SDR_SPEED_ADDR)
        |=> (^resp_r.data) == 1'b1)
        else $error("Status answer parity is not odd.");

    a_latch_clears: assert property (@(posedge mclk_i) disable iff (rst_i)
        (clr_v[0] && !stall_det_i) |=> !lat_r[0][`SDR_STALL_BIT])
        else $error("Stall latch not cleared by read.");

    a_latch_holds: assert property (@(posedge mclk_i) disable iff (rst_i)
        (lat_r[1][`SDR_THERM_SHDN_BIT] && !clr_v[1]) |=> lat_r[1][`SDR_THERM_SHDN_BIT])
        else $error("Shutdown latch lost without a read.");

    a_defect_live: assert property (@(posedge mclk_i) disable iff (rst_i)
        (rd_req && cmd_r.addr == `SDR_FAULT_SUM_ADDR)
        |=> resp_r.data[`SDR_DEFECT_BIT] == $past(defect_live)
            && (($past(lat_r[1][4:0]) & lat_r[1][4:0]) == $past(lat_r[1][4:0])))
        else $error("Defect bit wrong or its read cleared a latch.");

    a_frame_error: assert property (@(posedge mclk_i) disable iff (rst_i)
        (frame_end && misalign_s) |=> lat_r[1][`SDR_SPI_BIT])
        else $error("Framing error not latched.");

    a_speed_live: assert property (@(posedge mclk_i) disable iff (rst_i)
        (rd_req && cmd_r.addr == `SDR_SPEED_ADDR)
        |=> resp_r.data[7:0] == $past(speed_i))
        else $error("Speed answer does not match input.");

    a_zero_bits: assert property (@(posedge mclk_i) disable iff (rst_i)
        rd_req |=> !resp_r.data[9] && !(resp_r.addr inside
            {`SDR_PHASE_X_ADDR, `SDR_PHASE_Y_ADDR} && resp_r.data[7]))
        else $error("Reserved status bit reads as one.");

    a_write_ignored: assert property (@(posedge mclk_i) disable iff (rst_i)
        (req_fire && cmd_r.rw) |=> $stable(resp_r))
        else $error("A write changed the status answer.");

    a_low_supply_act: assert property (@(posedge mclk_i) disable iff (rst_i)
        undervoltage_det_i |=> (bridge_brake_o == $past(undervoltage_action_bit_i))
            && (bridge_open_o != bridge_brake_o))
        else $error("Under-voltage bridge action wrong.");

    a_ident_fixed: assert property (@(posedge mclk_i) disable iff (rst_i)
        (rd_req && cmd_r.addr == `SDR_IDENT_ADDR)
        |=> resp_r.data[7:0] == {DEV_ID, REV_ID})
        else $error("Identification answer wrong.");

    a_live_temp: assert property (@(posedge mclk_i) disable iff (rst_i)
        (rd_req && cmd_r.addr == `SDR_FAULT_SUM_ADDR)
        |=> resp_r.data[`SDR_COLD_BIT] == $past(cold_boost_allowed_i)
            && resp_r.data[`SDR_THERM_WARN_BIT] == $past(thermal_warning_i))
        else $error("Live temperature flags wrong in the answer.");

    a_pin_live: assert property (@(posedge mclk_i) disable iff (rst_i)
        (rd_req && cmd_r.addr == `SDR_PHASE_Y_ADDR)
        |=> resp_r.data[`SDR_STEP_BIT] == $past(step_s)
            && resp_r.data[`SDR_DIR_BIT] == $past(dir_s))
        else $error("Pin readback wrong in the answer.");

    a_ready_clears: assert property (@(posedge mclk_i) disable iff (rst_i)
        (clr_v[3] && !emf_i.ready) |=> !lat_r[3][`SDR_RDY_BIT])
        else $error("Result-ready latch not cleared by read.");

endmodule : sdr_status_regs

// ---- verification/sdr_spi_master.sv ----
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module sdr_spi_master (
    output logic      sclk_o,
    output logic      chip_select_low_n_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    // The serial clock idles low and only runs inside a frame.
    initial
    begin
        sclk_o              = 1'b0;
        chip_select_low_n_o = 1'b1;
        mosi_o              = 1'b0;
    end

    // Sending fewer than 16 edges is only done to provoke a framing error.
    task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
        rx = '0;
        // An odd offset keeps the serial edges off the core clock edges when the call starts on a core clock edge.
        #13;
        chip_select_low_n_o = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            mosi_o = tx[15 - i];
            #32;
            rx     = {rx[14:0], miso_i};
            sclk_o = 1'b1;
            #32;
            sclk_o = 1'b0;
        end
        #32;
        chip_select_low_n_o = 1'b1;
        mosi_o = ~mosi_o;
        // Gap well above the minimum idle time between frames.
        #70;
    endtask : xfer
endmodule : sdr_spi_master

// ---- verification/stepper_driver_status_regs_tb_top.sv ----
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module stepper_driver_status_regs_tb_top;
    import sdr_pkg::*;
    localparam logic [4:0] ID_DEV = 5'h0C; // Arbitrary value.
    localparam logic [2:0] ID_REV = 3'h2;  // Arbitrary value.
    logic       mclk, rst, sclk, cs_n, mosi, miso, miso_oe, b_open, b_brake;
    logic       step, dir, stall, sloss, lowv, lowvw, tshut, twarn, cold, ox, oy, act;
    sdr_short_t sx, sy;
    sdr_emf_t   emf;
    logic [7:0] spd;
    int         error_cnt = 0;
    int         samples_checked = 0;

    sdr_status_regs #(.DEV_ID(ID_DEV), .REV_ID(ID_REV)) u_sdr_status_regs (
        .mclk_i(mclk), .rst_i(rst), .sclk_i(sclk), .chip_select_low_n_i(cs_n),
        .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .step_clock_input_i(step),
        .direction_input_i(dir), .stall_det_i(stall), .step_loss_det_i(sloss),
        .undervoltage_det_i(lowv), .undervoltage_warn_det_i(lowvw),
        .thermal_shutdown_det_i(tshut), .thermal_warning_i(twarn),
        .cold_boost_allowed_i(cold), .open_x_det_i(ox), .open_y_det_i(oy),
        .short_x_det_i(sx), .short_y_det_i(sy), .emf_i(emf), .speed_i(spd),
        .undervoltage_action_bit_i(act), .bridge_open_o(b_open), .bridge_brake_o(b_brake)
    );

    sdr_spi_master u_sdr_spi_master (
        .sclk_o(sclk), .chip_select_low_n_o(cs_n), .mosi_o(mosi), .miso_i(miso)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    function automatic logic [9:0] wd(input logic [7:0] d);
        return {1'b0, ~^d, d};
    endfunction : wd

    // The answer comes in the following frame, so a write to 00h fetches it.
    task automatic rd(input logic [4:0] a, output logic [15:0] rx);
        logic [15:0] dummy;
        u_sdr_spi_master.xfer({1'b0, a, 10'h000}, 16, dummy);
        fork
            u_sdr_spi_master.xfer(16'h8000, 16, rx);
            begin
                #100;
                chk("miso_oe", 16'(miso_oe), 16'h0001);
            end
        join
    endtask : rd

    task automatic rchk(input logic [4:0] a, input logic [7:0] d);
        logic [15:0] rx;
        rd(a, rx);
        chk("status", rx, {1'b0, a, wd(d)});
    endtask : rchk

    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    initial
    begin
        #400000;
        error_cnt++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [15:0] rx;
        {step, dir, stall, sloss, lowv, lowvw, tshut, twarn, cold, ox, oy, act} = '0;
        sx  = '0;
        sy  = '0;
        emf = '0;
        spd = '0;
        rst = 1'b1;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        rchk(5'h05, 8'h40);
        rchk(5'h05, 8'h00);
        @(posedge mclk);
        {stall, sloss, lowv, lowvw, twarn, cold} <= '1;
        @(posedge mclk);
        {stall, sloss, lowv, lowvw} <= '0;
        rchk(5'h05, 8'h9F);
        rchk(5'h05, 8'h14);
        @(posedge mclk);
        {twarn, cold} <= '0;
        lowv <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("bridge", 16'({b_open, b_brake}), 16'h0002);
        act <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("bridge", 16'({b_open, b_brake}), 16'h0001);
        rchk(5'h05, 8'h02);
        @(posedge mclk);
        lowv <= 1'b0;
        rchk(5'h05, 8'h02);
        rchk(5'h05, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge mclk);
            sx <= sdr_short_t'(4'h1 << i);
            sy <= sdr_short_t'(4'h8 >> i);
            @(posedge mclk);
            sx <= '0;
            sy <= '0;
            rchk(5'h05, 8'h20);
            rchk(5'h06, 8'h01 << i);
            rchk(5'h07, 8'h08 >> i);
            rchk(5'h05, 8'h00);
        end
        @(posedge mclk);
        {ox, oy, tshut, step, dir} <= '1;
        @(posedge mclk);
        {ox, oy, tshut} <= '0;
        rchk(5'h07, 8'h70);
        rchk(5'h06, 8'h30);
        u_sdr_spi_master.xfer(16'h0000, 15, rx);
        rchk(5'h06, 8'h40);
        rchk(5'h08, {ID_DEV, ID_REV});
        @(posedge mclk);
        emf <= {1'b1, 1'b1, 1'b1, 5'h15};
        spd <= 8'hA5;
        @(posedge mclk);
        emf.ready <= 1'b0;
        rchk(5'h09, 8'hF5);
        rchk(5'h09, 8'h75);
        @(posedge mclk);
        emf <= {1'b0, 1'b0, 1'b0, 5'h0A};
        rchk(5'h09, 8'h0A);
        rchk(5'h0A, 8'hA5);
        u_sdr_spi_master.xfer({1'b1, 5'h0A, 10'h3FF}, 16, rx);
        rchk(5'h0A, 8'hA5);
        rd(5'h0B, rx);
        chk("unmapped", 16'(rx[9:0]), 16'h0000);
        end_of_test();
    end
endmodule : stepper_driver_status_regs_tb_top
